// *** logic/oag_top.sv ***
// operand address generator with bank register storage
module oag_top
	import oag_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire logic reqValid,
	input wire oag_mode_t reqMode,
	input wire oag_impl_t reqImplied,
	input wire logic [7:0] reqOpcode,
	input wire logic [2:0] reqRegCode,
	input wire logic reqWord,
	input wire logic reqIndexC,
	input wire logic [15:0] reqImm,
	input wire logic [15:0] stackPtr,
	input wire logic [15:0] hsRamLo,
	input wire logic bank_select_low,
	input wire logic bank_select_high,
	input wire logic regWrEn,
	input wire logic [4:0] regWrIdx,
	input wire logic [7:0] regWrData,
	output logic ackValid,
	output logic [15:0] effAddr,
	output logic effIsMem,
	output logic effIsSfr,
	output logic [4:0] regIdxLo,
	output logic [4:0] regIdxHi,
	output logic regIsPair,
	output logic [4:0] implDstIdx,
	output logic implDstPair,
	output logic addrFault,
	output logic opcodeKnown
);
	oag_rf_if rf();
	oag_bank_mem u_mem (
		.clock(clock),
		.sys_rst(sys_rst),
		.clkEn(clkEn),
		.rf(rf)
	);

	// request held while the bank read is in flight
	logic busy_q, busy_d;
	oag_mode_t mode_q;
	oag_impl_t impl_q;
	logic [7:0] opc_q;
	logic [2:0] code_q;
	logic word_q;
	logic [15:0] imm_q;
	logic [15:0] sp_q;
	logic [1:0] bank_q;
	logic [1:0] bank;
	logic [1:0] pairSel;

	// bank selection from the two flags
	// bank flags pick bank
	assign bank = {bank_select_high, bank_select_low};
	// pair number n covers bytes 2n, 2n+1
	assign pairSel = reqRegCode[1:0];

	// decode which bytes to fetch for the memory-side modes
	logic [2:0] fetchLo, fetchHi;
	assign fetchLo = (reqMode == OAG_M_INDIRECT) ? {pairSel, 1'b0} : OAG_R_L;
	assign fetchHi = (reqMode == OAG_M_INDIRECT) ? {pairSel, 1'b1} : OAG_R_H;
	logic [2:0] fetchIdx;
	// B or C picked by the instruction
	assign fetchIdx = reqIndexC ? OAG_R_C : OAG_R_B;

	assign rf.rdIdxA = oag_idx(bank, (reqMode == OAG_M_BASED_IDX &&
		!busy_q) ? fetchIdx : fetchLo);
	assign rf.rdIdxB = oag_idx(bank, fetchHi);
	assign rf.wrEn = regWrEn & clkEn;
	assign rf.wrIdx = regWrIdx;
	assign rf.wrData = regWrData;

	// based indexed needs a second cycle for the index byte
	logic idxPhase_q;
	logic [7:0] idxByte_q;

	// address arithmetic shared by both based forms
	function automatic logic [15:0] addOff(input logic [15:0] base,
		input logic [7:0] off);
		logic [16:0] s;
		s = {1'b0, base} + {9'h000, off};
		return s[15:0];
	endfunction

	logic [15:0] pairVal;
	assign pairVal = {rf.rdDataB, rf.rdDataA};

	// short direct and sfr addresses from the held byte
	logic [15:0] shortAddr, sfrAddr, addrComb;
	assign shortAddr = {OAG_SHORT_TOP, (imm_q[7:0] < OAG_SHORT_WRAP),
		imm_q[7:0]};
	assign sfrAddr = {OAG_SFR_PAGE, imm_q[7:0]};

	// effective address selection
	always_comb begin
		addrComb = OAG_ADDR_RST;
		case (mode_q)
			OAG_M_DIRECT: addrComb = imm_q;
			OAG_M_SHORT: addrComb = shortAddr;
			OAG_M_SFR: addrComb = sfrAddr;
			OAG_M_INDIRECT: addrComb = pairVal;
			OAG_M_BASED: addrComb = addOff(pairVal, imm_q[7:0]);
			OAG_M_BASED_IDX: addrComb = addOff(pairVal, idxByte_q);
			OAG_M_STACK: addrComb = sp_q;
			default: addrComb = OAG_ADDR_RST;
		endcase
	end

	// fault checks on the formed address
	logic faultComb;
	always_comb begin
		faultComb = 1'b0;
		case (mode_q)
			OAG_M_SHORT: faultComb = word_q & imm_q[0];
			OAG_M_SFR: faultComb = (imm_q[7:0] >= OAG_SFR_GAP_LO &&
				imm_q[7:0] <= OAG_SFR_GAP_HI) || (word_q & imm_q[0]);
			OAG_M_STACK: faultComb = (sp_q < hsRamLo) ||
				(sp_q > OAG_HSRAM_HI);
			default: faultComb = 1'b0;
		endcase
	end

	// short window upper part is SFR space
	logic sfrComb;
	assign sfrComb = (mode_q == OAG_M_SFR) ||
		(mode_q == OAG_M_SHORT && addrComb >= OAG_SFR_LO);

	logic knownComb;
	assign knownComb = (opc_q == OAG_OP_LD_A_BASE_B) ||
		(opc_q == OAG_OP_PUSH_DE);

	// register operand targets
	logic [4:0] rLo, rHi, iDst;
	logic iPair, isPair;
	assign rLo = oag_idx(bank_q, isPair ? {code_q[1:0], 1'b0} : code_q);
	assign rHi = oag_idx(bank_q, {code_q[1:0], 1'b1});
	assign isPair = (mode_q == OAG_M_REG16);
	// implied destinations
	// product into pair 0
	assign iPair = (impl_q == OAG_I_UNSIGNED_MULTIPLY) || (impl_q == OAG_I_UNSIGNED_WORD_DIVIDE);
	assign iDst = oag_idx(bank_q, iPair ? OAG_R_X : OAG_R_A);

	logic done;
	assign done = busy_q && !(mode_q == OAG_M_BASED_IDX && idxPhase_q);

	// capture request and hold until answer
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			busy_q <= 1'b0;
			idxPhase_q <= 1'b0;
			mode_q <= OAG_M_IMPLIED;
			impl_q <= OAG_I_NONE;
			opc_q <= 8'h00;
			code_q <= 3'h0;
			word_q <= 1'b0;
			imm_q <= OAG_ADDR_RST;
			sp_q <= OAG_ADDR_RST;
			bank_q <= 2'h0;
			idxByte_q <= 8'h00;
		end else if (clkEn) begin
			busy_q <= busy_d;
			if (reqValid && !busy_q) begin
				mode_q <= reqMode;
				impl_q <= reqImplied;
				opc_q <= reqOpcode;
				code_q <= reqRegCode;
				word_q <= reqWord;
				imm_q <= reqImm;
				sp_q <= stackPtr;
				bank_q <= bank;
				idxPhase_q <= (reqMode == OAG_M_BASED_IDX);
			end else if (idxPhase_q) begin
				idxByte_q <= rf.rdDataA;
				idxPhase_q <= 1'b0;
			end
		end
	end

	// one cycle of latency, two for based indexed
	assign busy_d = busy_q ? !done : reqValid;

	// answer registers
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			ackValid <= 1'b0;
			effAddr <= OAG_ADDR_RST;
			effIsMem <= 1'b0;
			effIsSfr <= 1'b0;
			regIdxLo <= 5'h00;
			regIdxHi <= 5'h00;
			regIsPair <= 1'b0;
			implDstIdx <= 5'h00;
			implDstPair <= 1'b0;
			addrFault <= 1'b0;
			opcodeKnown <= 1'b0;
		end else if (clkEn) begin
			ackValid <= done;
			if (done) begin
				effAddr <= addrComb;
				effIsMem <= !(mode_q inside {OAG_M_IMPLIED, OAG_M_REG8,
					OAG_M_REG16});
				effIsSfr <= sfrComb;
				regIdxLo <= rLo;
				regIdxHi <= rHi;
				regIsPair <= isPair;
				implDstIdx <= iDst;
				implDstPair <= iPair;
				addrFault <= faultComb;
				opcodeKnown <= knownComb;
			end
		end
	end

	// short direct stays in window
	shortWin_a: assert property (@(posedge clock) disable iff (sys_rst)
		ackValid && $past(mode_q) == OAG_M_SHORT |->
		effAddr >= OAG_SHORT_LO && effAddr <= OAG_SHORT_HI)
		else $error("short direct outside window");
	shortBit_a: assert property (@(posedge clock) disable iff (sys_rst)
		ackValid && $past(mode_q) == OAG_M_SHORT |->
		effAddr[8] == ($past(imm_q[7:0]) < 8'h20))
		else $error("short direct bit 8 wrong");
	sfrPage_a: assert property (@(posedge clock) disable iff (sys_rst)
		ackValid && $past(mode_q) == OAG_M_SFR |->
		effAddr == {8'hff, $past(imm_q[7:0])})
		else $error("sfr address wrong");
	directImm_a: assert property (@(posedge clock) disable iff (sys_rst)
		clkEn && reqValid && !busy_q && reqMode == OAG_M_DIRECT ##1 clkEn
		|=> ackValid && effAddr == $past(reqImm, 2))
		else $error("direct address wrong");
	idxLate_a: assert property (@(posedge clock) disable iff (sys_rst)
		clkEn && reqValid && !busy_q && reqMode == OAG_M_BASED_IDX ##1 clkEn
		|=> !ackValid)
		else $error("based indexed answered too early");
	implDst_a: assert property (@(posedge clock) disable iff (sys_rst)
		ackValid && $past(impl_q) == OAG_I_UNSIGNED_MULTIPLY |->
		implDstPair && implDstIdx[2:0] == 3'h0)
		else $error("multiply product target wrong");
	stackRam_a: assert property (@(posedge clock) disable iff (sys_rst)
		ackValid && $past(mode_q) == OAG_M_STACK && effAddr > 16'hfeff |->
		addrFault)
		else $error("stack outside high-speed RAM not flagged");
	sfrGap_a: assert property (@(posedge clock) disable iff (sys_rst)
		ackValid && $past(mode_q) == OAG_M_SFR && effAddr[7:4] == 4'hd |->
		addrFault)
		else $error("sfr gap not flagged");
	shortEven_a: assert property (@(posedge clock) disable iff (sys_rst)
		ackValid && $past(mode_q) == OAG_M_SHORT && $past(word_q) &&
		effAddr[0] |-> addrFault)
		else $error("odd short word not flagged");
	pairBytes_a: assert property (@(posedge clock) disable iff (sys_rst)
		ackValid && regIsPair |->
		regIdxLo[0] == 1'b0 && regIdxHi == {regIdxLo[4:1], 1'b1})
		else $error("pair byte indices wrong");

	coverShort_c: cover property (@(posedge clock) ackValid && effIsMem &&
		effAddr[15:8] == 8'hfe);
	coverSfr_c: cover property (@(posedge clock) ackValid && effIsSfr);
	coverIdx_c: cover property (@(posedge clock)
		ackValid && $past(mode_q) == OAG_M_BASED_IDX);
	coverFault_c: cover property (@(posedge clock) ackValid && addrFault);
	coverPair_c: cover property (@(posedge clock) ackValid && regIsPair);
endmodule

// *** inc/oag_pkg.sv ***
// shared constants and types for the operand address generator
package oag_pkg;
	localparam int OAG_AW = 16;
	localparam int OAG_DW = 8;
	// absolute byte register numbers
	localparam logic [2:0] OAG_R_X = 3'h0;
	localparam logic [2:0] OAG_R_A = 3'h1;
	localparam logic [2:0] OAG_R_C = 3'h2;
	localparam logic [2:0] OAG_R_B = 3'h3;
	localparam logic [2:0] OAG_R_E = 3'h4;
	localparam logic [2:0] OAG_R_D = 3'h5;
	localparam logic [2:0] OAG_R_L = 3'h6;
	localparam logic [2:0] OAG_R_H = 3'h7;
	// pair numbers
	localparam logic [1:0] OAG_RP_ACC = 2'h0;
	localparam logic [1:0] OAG_RP_BC = 2'h1;
	localparam logic [1:0] OAG_RP_DE = 2'h2;
	localparam logic [1:0] OAG_RP_BASE = 2'h3;
	// fixed address windows
	localparam logic [15:0] OAG_SHORT_LO = 16'hfe20;
	localparam logic [15:0] OAG_SHORT_HI = 16'hff1f;
	localparam logic [15:0] OAG_HSRAM_HI = 16'hfeff;
	localparam logic [15:0] OAG_SFR_LO = 16'hff00;
	localparam logic [7:0] OAG_SHORT_WRAP = 8'h20;
	localparam logic [6:0] OAG_SHORT_TOP = 7'h7f;
	localparam logic [7:0] OAG_SFR_PAGE = 8'hff;
	localparam logic [7:0] OAG_SFR_GAP_LO = 8'hd0;
	localparam logic [7:0] OAG_SFR_GAP_HI = 8'hdf;
	// documented opcodes
	localparam logic [7:0] OAG_OP_LD_A_BASE_B = 8'hab;
	localparam logic [7:0] OAG_OP_PUSH_DE = 8'hb5;
	// reset values
	localparam logic [15:0] OAG_ADDR_RST = 16'h0000;
	localparam logic [3:0] OAG_CYC_RST = 4'h0;
	// addressing modes
	typedef enum logic [3:0] {
		OAG_M_IMPLIED, OAG_M_REG8, OAG_M_REG16, OAG_M_DIRECT, OAG_M_SHORT,
		OAG_M_SFR, OAG_M_INDIRECT, OAG_M_BASED, OAG_M_BASED_IDX, OAG_M_STACK
	} oag_mode_t;
	// implied instruction classes
	typedef enum logic [2:0] {
		OAG_I_NONE, OAG_I_UNSIGNED_MULTIPLY, OAG_I_UNSIGNED_WORD_DIVIDE, OAG_I_DECADJ, OAG_I_DIGROT
	} oag_impl_t;
	// byte register file index: bank, register number
	function automatic logic [4:0] oag_idx(input logic [1:0] bank,
		input logic [2:0] r);
		return {bank, r};
	endfunction
endpackage

// *** inc/oag_rf_if.sv ***
// read and write port bundle between address generator and bank memory
interface oag_rf_if;
	logic [4:0] rdIdxA;
	logic [4:0] rdIdxB;
	logic [7:0] rdDataA;
	logic [7:0] rdDataB;
	logic wrEn;
	logic [4:0] wrIdx;
	logic [7:0] wrData;
	modport gen (output rdIdxA, output rdIdxB, input rdDataA,
		input rdDataB, output wrEn, output wrIdx, output wrData);
	modport mem (input rdIdxA, input rdIdxB, output rdDataA,
		output rdDataB, input wrEn, input wrIdx, input wrData);
endinterface

// *** logic/oag_bank_mem.sv ***
// four banks of eight byte registers, registered read data
module oag_bank_mem
	import oag_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clkEn,
	oag_rf_if.mem rf
);
	logic [7:0] mem [32];
	// reads land one cycle after the index, like a real array
	always_ff @(posedge clock) begin
		if (clkEn) begin
			if (rf.wrEn)
				mem[rf.wrIdx] <= rf.wrData;
			rf.rdDataA <= mem[rf.rdIdxA];
			rf.rdDataB <= mem[rf.rdIdxB];
		end
	end
endmodule

// *** dv/oag_mem_model.sv ***
// memory and sfr space seen behind the generated addresses
module oag_mem_model
	import oag_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic ackValid,
	input wire logic effIsSfr,
	input wire logic [15:0] effAddr,
	output logic [15:0] sfrHits,
	output logic [15:0] ramHits
);
	timeunit 1ns;
	timeprecision 1ps;
	// split high ram from sfr page
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			sfrHits <= 16'h0000;
			ramHits <= 16'h0000;
		end else if (ackValid && effIsSfr && effAddr >= 16'hff00) begin
			sfrHits <= sfrHits + 16'h0001;
		end else if (ackValid && effAddr <= 16'hfeff) begin
			ramHits <= ramHits + 16'h0001;
		end
	end
endmodule

// *** dv/operand_address_generator_tb.sv ***
// self-checking bench for the operand address generator
module operand_address_generator_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import oag_pkg::*;
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
	$display("mismatch at %0t: %h vs %h", $time, a, b); end end
	typedef struct packed {logic [36:0] v; logic [36:0] m;} oag_note_t;
	logic clock, sys_rst, clkEn, reqValid, reqWord, reqIndexC;
	logic bank_select_low, bank_select_high, regWrEn;
	oag_mode_t reqMode;
	oag_impl_t reqImplied;
	logic [7:0] reqOpcode, regWrData;
	logic [2:0] reqRegCode;
	logic [15:0] reqImm, stackPtr, hsRamLo, sfrHits, ramHits;
	logic [4:0] regWrIdx;
	logic ackValid, effIsMem, effIsSfr, regIsPair, implDstPair;
	logic addrFault, opcodeKnown;
	logic [15:0] effAddr;
	logic [4:0] regIdxLo, regIdxHi, implDstIdx;
	logic [7:0] regMirror [32];
	oag_note_t expQ [$];
	oag_note_t e;
	int n_fail, n_checks, cyc, seed, n;
	oag_top uut (.clock(clock), .sys_rst(sys_rst), .clkEn(clkEn),
		.reqValid(reqValid), .reqMode(reqMode), .reqImplied(reqImplied),
		.reqOpcode(reqOpcode), .reqRegCode(reqRegCode), .reqWord(reqWord),
		.reqIndexC(reqIndexC), .reqImm(reqImm), .stackPtr(stackPtr),
		.hsRamLo(hsRamLo), .bank_select_low(bank_select_low),
		.bank_select_high(bank_select_high), .regWrEn(regWrEn),
		.regWrIdx(regWrIdx), .regWrData(regWrData), .ackValid(ackValid),
		.effAddr(effAddr), .effIsMem(effIsMem), .effIsSfr(effIsSfr),
		.regIdxLo(regIdxLo), .regIdxHi(regIdxHi), .regIsPair(regIsPair),
		.implDstIdx(implDstIdx), .implDstPair(implDstPair),
		.addrFault(addrFault), .opcodeKnown(opcodeKnown));
	oag_mem_model mem (.clock(clock), .sys_rst(sys_rst),
		.ackValid(ackValid), .effIsSfr(effIsSfr), .effAddr(effAddr),
		.sfrHits(sfrHits), .ramHits(ramHits));
	// clock and hang guard
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc++;
		if (cyc == 12000) begin
			n_fail++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic wr(input logic [4:0] i, input logic [7:0] d);
		@(posedge clock);
		#1 regWrEn = 1'b1;
		regWrIdx = i;
		regWrData = d;
		regMirror[i] = d;
		@(posedge clock);
		#1 regWrEn = 1'b0;
	endtask
	// expected outputs, masked to what each mode defines
	function automatic oag_note_t mk(input logic [1:0] b);
		logic [15:0] a, bp;
		logic [7:0] s;
		logic [2:0] rc;
		logic f, sf;
		oag_note_t t;
		rc = reqRegCode;
		s = reqImm[7:0];
		bp = {regMirror[{b, 3'h7}], regMirror[{b, 3'h6}]};
		a = 16'h0000;
		f = 1'b0;
		sf = 1'b0;
		t.m = 37'h1;
		t.v = {36'h0, reqOpcode == 8'hab || reqOpcode == 8'hb5};
		case (reqMode)
			OAG_M_REG8: begin
				t.m[18:14] = 5'h1f;
				t.m[8] = 1'b1;
				t.v[18:14] = {b, rc};
			end
			OAG_M_REG16: begin
				t.m[18:8] = 11'h7ff;
				t.v[18:8] = {b, rc[1:0], 1'b0, b, rc[1:0], 1'b1, 1'b1};
			end
			OAG_M_IMPLIED: begin
				t.m[7:2] = 6'h3f;
				f = reqImplied inside {OAG_I_UNSIGNED_MULTIPLY, OAG_I_UNSIGNED_WORD_DIVIDE};
				t.v[7:2] = {b, f ? 3'h0 : 3'h1, f};
				f = 1'b0;
			end
			OAG_M_DIRECT: a = reqImm;
			OAG_M_SHORT: begin
				a = {7'h7f, s < 8'h20, s};
				sf = a >= 16'hff00;
				f = reqWord & s[0];
			end
			OAG_M_SFR: begin
				a = {8'hff, s};
				sf = 1'b1;
				f = (s[7:4] == 4'hd) | (reqWord & s[0]);
			end
			OAG_M_INDIRECT: a = {regMirror[{b, rc[1:0], 1'b1}],
				regMirror[{b, rc[1:0], 1'b0}]};
			OAG_M_BASED: a = bp + {8'h00, s};
			OAG_M_BASED_IDX: a = bp + {8'h00,
				regMirror[{b, reqIndexC ? 3'h2 : 3'h3}]};
			default: begin
				a = stackPtr;
				f = stackPtr < hsRamLo || stackPtr > 16'hfeff;
			end
		endcase
		if (reqMode inside {OAG_M_SHORT, OAG_M_SFR, OAG_M_STACK})
			t.m[1] = 1'b1;
		if (reqMode inside {OAG_M_SHORT, OAG_M_SFR})
			t.m[19] = 1'b1;
		if (reqMode >= OAG_M_DIRECT)
			t.m[36:21] = 16'hffff;
		t.m[20] = 1'b1;
		t.v[36:19] = {a, reqMode >= OAG_M_DIRECT, sf};
		t.v[1] = f;
		return t;
	endfunction
	// one request, held until its answer; stall freezes clkEn
	task automatic req(input int stall);
		@(posedge clock);
		#1 reqValid = 1'b1;
		expQ.push_back(mk({bank_select_high, bank_select_low}));
		@(posedge clock);
		#1 reqValid = 1'b0;
		n = 0;
		clkEn = (n >= stall);
		while (ackValid !== 1'b1 && n < 20) begin
			@(posedge clock);
			#1 n++;
			clkEn = (n >= stall);
		end
		`CHK(n, (reqMode == OAG_M_BASED_IDX ? 2 : 1) + stall)
	endtask
	// results are popped in order as each ack appears
	always @(posedge clock) begin
		if (ackValid === 1'b1) begin
			`CHK(expQ.size() != 0, 1'b1)
			if (expQ.size() != 0) begin
				e = expQ.pop_front();
				`CHK({effAddr, effIsMem, effIsSfr, regIdxLo, regIdxHi,
					regIsPair, implDstIdx, implDstPair, addrFault,
					opcodeKnown} & e.m, e.v & e.m)
			end
		end
	end
	initial begin
		seed = 99050;
		{clkEn, reqValid, reqWord, reqIndexC, regWrEn} = 5'h10;
		{bank_select_low, bank_select_high} = 2'h0;
		reqMode = OAG_M_DIRECT;
		reqImplied = OAG_I_NONE;
		{reqOpcode, regWrData, reqRegCode, regWrIdx} = 24'h0;
		{reqImm, stackPtr} = 32'h0;
		hsRamLo = 16'hfb00;
		sys_rst = 1'b1;
		repeat (16) @(posedge clock);
		#1 sys_rst = 1'b0;
		for (int i = 0; i < 32; i++)
			wr(i[4:0], $random(seed));
		$display("test register fill done");
		// random operands, every mode and implied class
		for (int i = 0; i < 500; i++) begin
			reqMode = oag_mode_t'(i % 10);
			reqImplied = oag_impl_t'(reqMode == OAG_M_IMPLIED ?
				1 + (i / 10) % 4 : 0);
			{reqImm, reqRegCode, reqWord, reqIndexC} = $random(seed);
			{bank_select_low, bank_select_high} = $random(seed);
			reqOpcode = i % 7 == 0 ? 8'hab : i % 7 == 1 ? 8'hb5
				: $random(seed);
			stackPtr = 16'hfa00 + 16'($unsigned($random(seed)) % 1536);
			req(i % 50 == 3 ? 3 : 0);
		end
		$display("test random operands done");
		// base pair carry out of bit 15 is dropped
		wr(5'h06, 8'hff);
		wr(5'h07, 8'hff);
		{bank_select_low, bank_select_high} = 2'h0;
		reqMode = OAG_M_BASED;
		reqImm = 16'h00ff;
		req(0);
		reqMode = OAG_M_BASED_IDX;
		req(0);
		`CHK(sfrHits != 0 && ramHits != 0, 1'b1)
		$display("test base wrap done");
		repeat (4) @(posedge clock);
		finish_test();
	end
endmodule
